/* hw/ncos_top.sv */
// Oscillator select pins, overrange flags and sleep control for two channels
// Assumes one 10 MHz clock; select and sleep pins are asynchronous
//
// Behaviour
// R01: Each down-converter forms a two-bit index from a low and a high select pin and mixes with that oscillator.
// R02: Pin selection applies only while the output format mode is a complex format.
// R03: Every oscillator keeps advancing its phase whether selected or not.
// R04: With the select source setting at one, the active oscillator follows the select pins.
// R05: Select pins are asynchronous and may change at any time.
// R06: The first overrange flag rises when the magnitude exceeds the first threshold.
// R07: The second overrange flag rises when the magnitude exceeds the second threshold.
// R08: An overrange flag stays high at least the programmed minimum pulse length.
// R09: While the sleep input is high, analog circuits and serializer outputs are disabled.
// R10: Each select pin passes a two-stage synchroniser before the index updates.
// R11: A new exceedance restarts the pulse count; the flag falls only after a quiet expiry.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
module ncos_top
  import ncos_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Select and sleep pins
  input wire logic ddc_a_osc_sel_lo_i,
  input wire logic ddc_a_osc_sel_hi_i,
  input wire logic ddc_b_osc_sel_lo_i,
  input wire logic ddc_b_osc_sel_hi_i,
  input wire logic sleep_input_i,
  // Converter magnitudes
  input wire logic [NCOS_MAG_W-1:0] chan_a_mag_i,
  input wire logic [NCOS_MAG_W-1:0] chan_b_mag_i,
  // Register port
  input wire logic [NCOS_ADDR_W-1:0] reg_addr_i,
  input wire logic [NCOS_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [NCOS_DATA_W-1:0] reg_rdata_o,
  // Overrange flags
  output logic chan_a_over_flag_first_o,
  output logic chan_a_over_flag_second_o,
  output logic chan_b_over_flag_first_o,
  output logic chan_b_over_flag_second_o,
  // Mixer, power and interrupt
  output ncos_mix_t ddc_a_mix_o,
  output ncos_mix_t ddc_b_mix_o,
  output logic analog_en_o,
  output logic serializer_en_o,
  output logic irq_o
);
  // Synchronisers: 4 select pins plus sleep
  logic [4:0] pin_raw;
  logic [4:0] sync1_r, sync2_r;
  assign pin_raw = {sleep_input_i, ddc_b_osc_sel_hi_i, ddc_b_osc_sel_lo_i,
                    ddc_a_osc_sel_hi_i, ddc_a_osc_sel_lo_i};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw; // [R05] [R10]
      sync2_r <= sync1_r; // [R10]
    end
  end

  logic sleep_s;
  logic [NCOS_SEL_W-1:0] pin_sel [NCOS_CHANS];
  assign sleep_s = sync2_r[4];
  assign pin_sel[0] = {sync2_r[1], sync2_r[0]}; // [R01]
  assign pin_sel[1] = {sync2_r[3], sync2_r[2]}; // [R01]

  // Registers
  logic [NCOS_DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [NCOS_DATA_W-1:0] thr_r, thr_nxt;
  logic [NCOS_CNT_W-1:0] pulse_r, pulse_nxt;
  logic [NCOS_EVT_W-1:0] stat_r, stat_nxt;
  logic [NCOS_DATA_W-1:0] rdata_nxt;
  logic [NCOS_EVT_W-1:0] evt;
  logic src_pins, cplx_mode;
  logic [NCOS_EVT_W-1:0] irq_mask;
  logic [NCOS_MAG_W-1:0] thr_first, thr_second;

  assign src_pins = ctrl_r[NCOS_CTRL_SRC_BIT];
  assign cplx_mode = ctrl_r[NCOS_CTRL_CPLX_BIT];
  assign irq_mask = ctrl_r[NCOS_CTRL_MASK_LSB +: NCOS_EVT_W];
  assign thr_first = thr_r[0 +: NCOS_MAG_W];
  assign thr_second = thr_r[NCOS_THR2_LSB +: NCOS_MAG_W];

  always_comb begin
    ctrl_nxt = ctrl_r;
    thr_nxt = thr_r;
    pulse_nxt = pulse_r;
    stat_nxt = stat_r;
    rdata_nxt = '0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        NCOS_REG_CTRL: ctrl_nxt = reg_wdata_i;
        NCOS_REG_THR: thr_nxt = reg_wdata_i;
        NCOS_REG_PULSE: pulse_nxt = reg_wdata_i[NCOS_CNT_W-1:0];
        NCOS_REG_STAT: stat_nxt = stat_r & ~reg_wdata_i[NCOS_EVT_W-1:0];
        default: ;
      endcase
    end
    stat_nxt = stat_nxt | evt; // Set wins over clear
    if (reg_rd_i) begin
      case (reg_addr_i)
        NCOS_REG_CTRL: rdata_nxt = ctrl_r;
        NCOS_REG_THR: rdata_nxt = thr_r;
        NCOS_REG_PULSE: rdata_nxt = {{(NCOS_DATA_W-NCOS_CNT_W){1'b0}}, pulse_r};
        NCOS_REG_STAT: rdata_nxt = {{(NCOS_DATA_W-NCOS_EVT_W){1'b0}}, stat_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= '0;
      thr_r <= {{(NCOS_DATA_W-NCOS_THR2_LSB-NCOS_MAG_W){1'b0}}, NCOS_THR_RST,
                {(NCOS_THR2_LSB-NCOS_MAG_W){1'b0}}, NCOS_THR_RST};
      pulse_r <= NCOS_PULSE_RST;
      stat_r <= '0;
      reg_rdata_o <= '0;
      irq_o <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      pulse_r <= pulse_nxt;
      stat_r <= stat_nxt;
      reg_rdata_o <= rdata_nxt;
      irq_o <= |(stat_nxt & irq_mask);
    end
  end

  // Oscillators: all phases advance every cycle
  logic [NCOS_PHASE_W-1:0] phase_r [NCOS_CHANS][NCOS_OSCS];
  logic [NCOS_PHASE_W-1:0] phase_nxt [NCOS_CHANS][NCOS_OSCS];
  logic [NCOS_SEL_W-1:0] act_r [NCOS_CHANS];
  logic [NCOS_SEL_W-1:0] act_nxt [NCOS_CHANS];
  ncos_mix_t mix_nxt [NCOS_CHANS];

  genvar c, o;
  generate
    for (c = 0; c < NCOS_CHANS; c++) begin : g_chan
      for (o = 0; o < NCOS_OSCS; o++) begin : g_osc
        always_comb begin
          phase_nxt[c][o] = phase_r[c][o] + NCOS_STEP_BASE * NCOS_PHASE_W'(o + 1 + c); // [R03]
        end
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
          if (!arst_n_i) begin
            phase_r[c][o] <= '0;
          end else begin
            phase_r[c][o] <= phase_nxt[c][o];
          end
        end
      end
      always_comb begin
        act_nxt[c] = act_r[c];
        if (cplx_mode) begin // [R02]
          if (src_pins) begin
            act_nxt[c] = pin_sel[c]; // [R04]
          end else begin
            act_nxt[c] = ctrl_r[NCOS_CTRL_SWSEL_LSB + c*NCOS_SEL_W +: NCOS_SEL_W];
          end
        end
        mix_nxt[c].sel = act_r[c];
        mix_nxt[c].phase = phase_r[c][act_r[c]]; // [R01]
      end
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          act_r[c] <= '0;
        end else begin
          act_r[c] <= act_nxt[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ddc_a_mix_o <= '0;
      ddc_b_mix_o <= '0;
      analog_en_o <= 1'b0;
      serializer_en_o <= 1'b0;
    end else begin
      ddc_a_mix_o <= mix_nxt[0];
      ddc_b_mix_o <= mix_nxt[1];
      analog_en_o <= !sleep_s; // [R09]
      serializer_en_o <= !sleep_s; // [R09]
    end
  end

  // Overrange flags, order: a first, a second, b first, b second
  logic [3:0] flag;
  logic [NCOS_MAG_W-1:0] f_mag [4];
  logic [NCOS_MAG_W-1:0] f_thr [4];
  assign f_mag[0] = chan_a_mag_i;
  assign f_mag[1] = chan_a_mag_i;
  assign f_mag[2] = chan_b_mag_i;
  assign f_mag[3] = chan_b_mag_i;
  assign f_thr[0] = thr_first; // [R06]
  assign f_thr[1] = thr_second; // [R07]
  assign f_thr[2] = thr_first; // [R06]
  assign f_thr[3] = thr_second; // [R07]

  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_flag
      ncos_over_flag u_flag (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .mag_i(f_mag[f]),
        .thr_i(f_thr[f]),
        .min_len_i(pulse_r), // [R08] [R11]
        .enable_i(!sleep_s),
        .flag_o(flag[f]),
        .rise_o(evt[f])
      );
    end
  endgenerate

  assign chan_a_over_flag_first_o = flag[0];
  assign chan_a_over_flag_second_o = flag[1];
  assign chan_b_over_flag_first_o = flag[2];
  assign chan_b_over_flag_second_o = flag[3];

  // Checks
  a_sel_follows_pins: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (cplx_mode && src_pins) |=> act_r[0] == $past(pin_sel[0])) // [R04]
    else $error("channel a index did not follow pins");
  a_sel_held_real: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !$past(cplx_mode) |-> $stable(act_r[1])) // [R02]
    else $error("index changed outside complex mode");
  a_phase_runs: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    1 |=> phase_r[0][3] != $past(phase_r[0][3])) // [R03]
    else $error("unselected oscillator stalled");
  a_mix_pick: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    1 |=> ddc_a_mix_o.phase == $past(phase_r[0][act_r[0]])) // [R01]
    else $error("mixer phase not from active oscillator");
  a_sync_two: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(ddc_a_osc_sel_lo_i) ##1 ddc_a_osc_sel_lo_i |=> sync2_r[0]) // [R10]
    else $error("synchroniser latency wrong");
  a_over_first: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!sleep_s && chan_a_mag_i > thr_first) |=> chan_a_over_flag_first_o) // [R06]
    else $error("first flag missed exceedance");
  a_over_second: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!sleep_s && chan_b_mag_i > thr_second) |=> chan_b_over_flag_second_o) // [R07]
    else $error("second flag missed exceedance");
  a_pulse_min: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ($rose(flag[0]) && pulse_r == 16'h0003 && $stable(pulse_r)) |-> flag[0][*3]) // [R08] [R11]
    else $error("flag shorter than minimum");
  a_sleep_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    sleep_s |=> !analog_en_o && !serializer_en_o) // [R09]
    else $error("outputs alive in sleep");
endmodule : ncos_top

/* hw/ncos_pkg.sv */
// Shared constants and carriers for oscillator select and overrange pin logic
// Assumes a single 10 MHz clock domain and a plain strobe register port
package ncos_pkg;
  localparam int NCOS_CHANS = 2;
  localparam int NCOS_OSCS = 4;
  localparam int NCOS_SEL_W = 2;
  localparam int NCOS_MAG_W = 12;
  localparam int NCOS_PHASE_W = 32;
  localparam int NCOS_CNT_W = 16;
  localparam int NCOS_ADDR_W = 4;
  localparam int NCOS_DATA_W = 32;
  // Register offsets (byte addresses)
  localparam logic [NCOS_ADDR_W-1:0] NCOS_REG_CTRL = 4'h0;
  localparam logic [NCOS_ADDR_W-1:0] NCOS_REG_THR = 4'h4;
  localparam logic [NCOS_ADDR_W-1:0] NCOS_REG_PULSE = 4'h8;
  localparam logic [NCOS_ADDR_W-1:0] NCOS_REG_STAT = 4'hc;
  // Ctrl fields, second threshold field and event width
  localparam int NCOS_CTRL_SRC_BIT = 0;
  localparam int NCOS_CTRL_CPLX_BIT = 1;
  localparam int NCOS_CTRL_MASK_LSB = 4;
  localparam int NCOS_CTRL_SWSEL_LSB = 8;
  localparam int NCOS_THR2_LSB = 16;
  localparam int NCOS_EVT_W = 4;
  // Reset values, phase step base and count step
  localparam logic [NCOS_MAG_W-1:0] NCOS_THR_RST = 12'hfff;
  localparam logic [NCOS_CNT_W-1:0] NCOS_PULSE_RST = 16'h0001;
  localparam logic [NCOS_PHASE_W-1:0] NCOS_STEP_BASE = 32'h0100_0000;
  localparam logic [NCOS_CNT_W-1:0] NCOS_CNT_ONE = 16'h0001;

  typedef struct packed {
    logic [NCOS_SEL_W-1:0] sel;
    logic [NCOS_PHASE_W-1:0] phase;
  } ncos_mix_t;

  typedef enum logic [1:0] {
    NCOS_FLAG_IDLE = 2'b01,
    NCOS_FLAG_HELD = 2'b10
  } ncos_flag_st_t;
endpackage : ncos_pkg

/* hw/ncos_over_flag.sv */
// One overrange flag with minimum pulse length stretch
// Assumes magnitude and threshold come from the same clock domain
`timescale 1ns/1ns
module ncos_over_flag
  import ncos_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Detection
  input wire logic [NCOS_MAG_W-1:0] mag_i,
  input wire logic [NCOS_MAG_W-1:0] thr_i,
  input wire logic [NCOS_CNT_W-1:0] min_len_i,
  input wire logic enable_i,
  // Flag
  output logic flag_o,
  output logic rise_o
);
  ncos_flag_st_t st_r, st_nxt;
  logic [NCOS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic rise_nxt;
  logic hit;

  assign hit = enable_i && (mag_i > thr_i);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rise_nxt = 1'b0;
    case (st_r)
      NCOS_FLAG_IDLE: begin
        if (hit) begin
          st_nxt = NCOS_FLAG_HELD;
          cnt_nxt = min_len_i;
          rise_nxt = 1'b1;
        end
      end
      NCOS_FLAG_HELD: begin
        if (hit) begin
          cnt_nxt = min_len_i;
        end else if (cnt_r <= NCOS_CNT_ONE) begin
          st_nxt = NCOS_FLAG_IDLE;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - NCOS_CNT_ONE;
        end
      end
      default: begin
        st_nxt = NCOS_FLAG_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= NCOS_FLAG_IDLE;
      cnt_r <= '0;
      rise_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rise_o <= rise_nxt;
    end
  end

  assign flag_o = (st_r == NCOS_FLAG_HELD);
endmodule : ncos_over_flag

/* verif/ncos_pin_partner.sv */
// Model of the external controller driving select and sleep pins
// Assumes bench commands; pins move with no fixed phase to the clock
`timescale 1ns/1ns
module ncos_pin_partner #(
  parameter int DLY_NS = 37
) (
  // Command from bench
  input wire logic [4:0] cmd_i,
  // Pins toward the block
  output logic [3:0] sel_pins_o,
  output logic sleep_o
);
  initial {sleep_o, sel_pins_o} = 5'h00;
  // Pins change off the clock edge
  always @(cmd_i) {sleep_o, sel_pins_o} <= #(DLY_NS) cmd_i;
endmodule : ncos_pin_partner

/* verif/ncos_top_tb.sv */
// Self-checking bench for select pins, overrange flags, sleep and registers
// Assumes the pin partner model and a 10 MHz clock
`timescale 1ns/1ns
module ncos_top_tb
  import ncos_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] pin_cmd = 5'h00;
  logic [3:0] sel_pins;
  logic sleep_pin;
  logic [NCOS_MAG_W-1:0] mag_a = 12'h000;
  logic [NCOS_MAG_W-1:0] mag_b = 12'h000;
  logic [NCOS_ADDR_W-1:0] reg_addr = 4'h0;
  logic [NCOS_DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [NCOS_DATA_W-1:0] reg_rdata;
  logic [3:0] flags;
  ncos_mix_t mix_a;
  ncos_mix_t mix_b;
  logic analog_en;
  logic ser_en;
  logic irq;
  logic rd_pend = 1'b0;
  logic counting = 1'b0;
  logic [31:0] exp_q[$];
  logic [NCOS_PHASE_W-1:0] ph_a;
  logic [NCOS_PHASE_W-1:0] ph_b;
  int err_count = 0;
  int checks_done = 0;
  int seed = 65669;
  int hi_cnt[4];

  always #50 ref_clk_i = ~ref_clk_i;

  ncos_pin_partner #(.DLY_NS(37)) i_ncos_pin_partner (.cmd_i(pin_cmd), .sel_pins_o(sel_pins), .sleep_o(sleep_pin));
  ncos_top i_ncos_top (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .ddc_a_osc_sel_lo_i(sel_pins[0]), .ddc_a_osc_sel_hi_i(sel_pins[1]),
    .ddc_b_osc_sel_lo_i(sel_pins[2]), .ddc_b_osc_sel_hi_i(sel_pins[3]),
    .sleep_input_i(sleep_pin), .chan_a_mag_i(mag_a), .chan_b_mag_i(mag_b),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .chan_a_over_flag_first_o(flags[0]), .chan_a_over_flag_second_o(flags[1]),
    .chan_b_over_flag_first_o(flags[2]), .chan_b_over_flag_second_o(flags[3]),
    .ddc_a_mix_o(mix_a), .ddc_b_mix_o(mix_b), .analog_en_o(analog_en),
    .serializer_en_o(ser_en), .irq_o(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Expected read data is noted here and compared by the watcher
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
  endtask : reg_read

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : settle

  task automatic over_pulse(input int n, input logic [11:0] va, input logic [11:0] vb);
    foreach (hi_cnt[i]) hi_cnt[i] = 0;
    @(posedge ref_clk_i);
    counting <= 1'b1;
    mag_a <= va;
    mag_b <= vb;
    repeat (n) @(posedge ref_clk_i);
    mag_a <= 12'h000;
    mag_b <= 12'h000;
    repeat (12) @(posedge ref_clk_i);
    counting <= 1'b0;
  endtask : over_pulse

  always @(posedge ref_clk_i) rd_pend <= reg_rd;
  always @(negedge ref_clk_i) begin
    if (rd_pend && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
    if (counting) foreach (hi_cnt[i]) hi_cnt[i] += int'(flags[i] === 1'b1);
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    give_verdict();
  end

  initial begin
    settle(2);
    check(analog_en, 1'b0);
    @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    reg_read(NCOS_REG_THR, 32'h0fff_0fff);
    reg_read(NCOS_REG_PULSE, 32'h0000_0001);
    reg_read(4'h2, 32'h0000_0000);
    $display("test reset done");
    reg_write(NCOS_REG_CTRL, 32'h0000_00f3);
    for (int s = 0; s < 4; s++) begin
      pin_cmd <= {1'b0, 2'(3 - s), 2'(s)};
      settle(7);
      check(mix_a.sel, 32'(s));
      check(mix_b.sel, 32'(3 - s));
      ph_a = mix_a.phase;
      ph_b = mix_b.phase;
      settle(1);
      check(mix_a.phase !== ph_a && mix_b.phase !== ph_b, 1'b1);
    end
    reg_write(NCOS_REG_CTRL, 32'h0000_06f2);
    settle(4);
    check(mix_a.sel, 32'h2);
    check(mix_b.sel, 32'h1);
    $display("test select done");
    reg_write(NCOS_REG_THR, 32'h0200_0100);
    reg_write(NCOS_REG_PULSE, 32'h0000_0003);
    for (int n = 1; n < 3; n++) begin
      over_pulse(n, 12'h150, 12'h201 + 12'($random(seed) & 32'h3fe));
      check(hi_cnt[0], 32'(n + 2));
      check(hi_cnt[1], 32'h0);
      check(hi_cnt[2], 32'(n + 2));
      check(hi_cnt[3], 32'(n + 2));
    end
    settle(0);
    check(irq, 1'b1);
    reg_read(NCOS_REG_STAT, 32'h0000_000d);
    reg_write(NCOS_REG_STAT, 32'h0000_000f);
    settle(2);
    check(irq, 1'b0);
    reg_read(NCOS_REG_STAT, 32'h0000_0000);
    $display("test overrange done");
    pin_cmd <= 5'h10;
    settle(5);
    check(analog_en, 1'b0);
    check(ser_en, 1'b0);
    over_pulse(1, 12'h150, 12'h000);
    check(hi_cnt[0], 32'h0);
    pin_cmd <= 5'h00;
    settle(5);
    check(analog_en & ser_en, 1'b1);
    $display("test sleep done");
    settle(2);
    give_verdict();
  end
endmodule : ncos_top_tb
